//--- dv/gtc_pins_model.sv
// far-side pins of the timer: external count clock, low-power osc
// assumes run is raised only for whole periods of eight hclk
`timescale 1ns/1ns
module gtc_pins_model (
    input wire logic hclk,
    input wire logic run,
    output logic ext_clock_pin,
    output logic lp_osc_clock
);
    logic [1:0] ph = 2'h0;
    // no crystal fitted, so the oscillator pin stands low
    assign lp_osc_clock = 1'b0;
    initial ext_clock_pin = 1'b0;
    // pin stands low between bursts, so a burst opens with a rise
    always @(posedge hclk) begin
        ph <= run ? ph + 2'h1 : 2'h0;
        if (!run)
            ext_clock_pin <= 1'b0;
        else if (ph == 2'h3)
            ext_clock_pin <= ~ext_clock_pin;
    end
endmodule // gtc_pins_model

//--- dv/gtc_timer_chk.sv
// assertions on the timer's bus and request outputs
// assumes hready looped from hreadyout and a single master
`timescale 1ns/1ns
module gtc_timer_chk (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire irq_request,
    input wire wake_request
);
    wire bus_take = clk_en && hsel && hready && htrans[1];
    wire wr_take = bus_take && hwrite;
    wire rd_take = bus_take && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // address phase of a write, then its data phase
    sequence s_wr(logic [7:0] a);
        wr_take && haddr[7:0] == a ##1 clk_en;
    endsequence
    a_resp_okay:
        assert property (!hresp) else $error("error response");
    a_zero_wait:
        assert property (hreadyout) else $error("wait state");
    a_byte_regs:
        assert property (hrdata[31:8] == 24'h0) else $error("high bits set");
    a_gie_masks:
        assert property (s_wr(8'h2C) ##0 !hwdata[7] |=> !irq_request)
        else $error("request without global enable");
    a_periph_irq_enable_masks:
        assert property (s_wr(8'h2C) ##0 !hwdata[6] |=>
            !irq_request && !wake_request) else $error("periph_irq_enable ignored");
    a_ovf_en_masks:
        assert property (s_wr(8'h20) ##0 !hwdata[0] |=>
            !irq_request && !wake_request) else $error("enable ignored");
    a_flag_holds:
        assert property (irq_request && !$past(wr_take) |=> irq_request)
        else $error("request dropped without a write");
    a_rdata_stands:
        assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("read data moved");
endmodule // gtc_timer_chk

//--- dv/gtc_timer_test.sv
// self-checking bench: register bus, count modes, gate, overflow, sleep
// assumes the pin model drives the external clock pin
`timescale 1ns/1ns
module gtc_timer_test;
    typedef struct packed {
        logic [7:0] ctrl, gsel;
        logic [2:0] gcx;
        logic [11:0] cyc;
        logic [7:0] lo, hi;
    } gtc_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic run = 1'b0;
    logic gate_pin = 1'b0;
    logic comparator_output = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, irq_request, wake_request;
    logic ext_clock_pin, lp_osc_clock;
    int n_errors = 0;
    int total_checks = 0;
    gtc_row_t rows [13];

    always #5 hclk = ~hclk;

    gtc_timer dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_clock_pin(ext_clock_pin), .lp_osc_clock(lp_osc_clock),
        .gate_pin(gate_pin), .comparator_output(comparator_output),
        .irq_request(irq_request), .wake_request(wake_request));
    gtc_pins_model pins_u (.hclk(hclk), .run(run),
        .ext_clock_pin(ext_clock_pin), .lp_osc_clock(lp_osc_clock));

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        hwrite <= w;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] lo, hi);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] lo, hi);
        bus(1'b0, a, 32'h0);
        chk(rd, lo, hi);
    endtask

    task end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #300000;
        n_errors++;
        end_sim;
    end

    initial begin
        // internal rows run 128 cycles per prescale step, so 32 counts
        rows[0] = {8'h01, 8'h00, 3'b000, 12'd118, 8'd31, 8'd33};
        rows[1] = {8'h11, 8'h00, 3'b000, 12'd246, 8'd31, 8'd33};
        rows[2] = {8'h21, 8'h00, 3'b000, 12'd502, 8'd31, 8'd33};
        rows[3] = {8'h31, 8'h00, 3'b000, 12'd1014, 8'd31, 8'd33};
        // 33 rises: the first follows no fall and is lost
        rows[4] = {8'h03, 8'h00, 3'b001, 12'd264, 8'd32, 8'd32};
        rows[5] = {8'h07, 8'h00, 3'b001, 12'd264, 8'd32, 8'd32};
        rows[6] = {8'h41, 8'h00, 3'b000, 12'd118, 8'd0, 8'd0};
        rows[7] = {8'h41, 8'h00, 3'b100, 12'd118, 8'd31, 8'd33};
        rows[8] = {8'hC1, 8'h00, 3'b000, 12'd118, 8'd31, 8'd33};
        rows[9] = {8'hC1, 8'h02, 3'b010, 12'd118, 8'd0, 8'd0};
        rows[10] = {8'h43, 8'h00, 3'b001, 12'd264, 8'd0, 8'd0};
        rows[11] = {8'h00, 8'h00, 3'b000, 12'd118, 8'd0, 8'd0};
        rows[12] = {8'h09, 8'h00, 3'b000, 12'd118, 8'd31, 8'd33};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h10, 0, 0);
        rdc(8'h24, 2, 2);
        rdc(8'h30, 0, 0);
        bus(1'b1, 8'h10, 32'hFE);
        rdc(8'h10, 32'hFE, 32'hFE);
        for (int i = 0; i < 13; i++) begin
            gate_pin <= rows[i].gcx[2];
            comparator_output <= rows[i].gcx[1];
            bus(1'b1, 8'h10, 32'h0);
            bus(1'b1, 8'h14, 32'h0);
            bus(1'b1, 8'h18, 32'h0);
            bus(1'b1, 8'h24, {24'h0, rows[i].gsel});
            bus(1'b1, 8'h10, {24'h0, rows[i].ctrl});
            run <= rows[i].gcx[0];
            repeat (rows[i].cyc) @(posedge hclk);
            run <= 1'b0;
            repeat (8) @(posedge hclk);
            bus(1'b1, 8'h10, {24'h0, rows[i].ctrl & 8'hFE});
            rdc(8'h14, rows[i].lo, rows[i].hi);
            rdc(8'h18, 0, 0);
        end
        bus(1'b1, 8'h14, 32'hFD);
        bus(1'b1, 8'h18, 32'hFF);
        bus(1'b1, 8'h20, 32'h1);
        bus(1'b1, 8'h2C, 32'hC0);
        bus(1'b1, 8'h10, 32'h1);
        repeat (38) @(posedge hclk);
        bus(1'b1, 8'h10, 32'h0);
        chk(irq_request, 1, 1);
        rdc(8'h18, 0, 0);
        rdc(8'h14, 6, 9);
        rdc(8'h1C, 1, 1);
        bus(1'b1, 8'h2C, 32'h40);
        @(posedge hclk);
        chk(irq_request, 0, 0);
        bus(1'b1, 8'h1C, 32'h0);
        rdc(8'h1C, 0, 0);
        // asynchronous counting in sleep, overflow wakes
        bus(1'b1, 8'h2C, 32'hC0);
        bus(1'b1, 8'h14, 32'hF0);
        bus(1'b1, 8'h18, 32'hFF);
        bus(1'b1, 8'h28, 32'h1);
        bus(1'b1, 8'h10, 32'h07);
        run <= 1'b1;
        repeat (136) @(posedge hclk);
        run <= 1'b0;
        repeat (8) @(posedge hclk);
        rdc(8'h28, 0, 0);
        chk(wake_request, 0, 0);
        rdc(8'h1C, 1, 1);
        rdc(8'h14, 0, 0);
        end_sim;
    end
endmodule // gtc_timer_test

bind gtc_timer gtc_timer_chk chk_u (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_request(irq_request),
    .wake_request(wake_request));

//--- pkg/gtc_map.vh
// register map, field positions, reset values and timing for the timer
// assumes word-aligned ahb-lite access, 32-bit data, 100 MHz hclk
`ifndef GTC_MAP_VH
`define GTC_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GTC_OFS_CONTROL 8'h10
`define GTC_OFS_COUNT_LOW 8'h14
`define GTC_OFS_COUNT_HIGH 8'h18
`define GTC_OFS_FLAGS 8'h1C
`define GTC_OFS_ENABLES 8'h20
`define GTC_OFS_GATE_CTRL 8'h24
`define GTC_OFS_SYSTEM 8'h28
`define GTC_OFS_IRQ_CTRL 8'h2C

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define GTC_BIT_ON 0
`define GTC_BIT_CS 1
`define GTC_BIT_SYNC 2
`define GTC_BIT_LPOSC 3
`define GTC_BIT_PS_LO 4
`define GTC_BIT_PS_HI 5
`define GTC_BIT_GE 6
`define GTC_BIT_GINV 7

// flags register, enables register, interrupt control, gate control, system register
`define GTC_BIT_OVF 0
`define GTC_BIT_OVF_EN 0
`define GTC_BIT_PERIPH_IRQ_ENABLE 6
`define GTC_BIT_GIE 7
`define GTC_BIT_GSS 1
`define GTC_BIT_SLEEP 0
`define GTC_BIT_INTERNAL_OSCILLATOR 1

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define GTC_RST_CONTROL 8'h00
`define GTC_RST_GATE_CTRL 8'h02
`define GTC_RST_COUNT 16'h0000
`define GTC_COUNT_MAX 16'hFFFF
// instruction cycle is four oscillator periods
`define GTC_INSTR_DIV 2'h3
`endif

//--- rtl/gtc_timer.v
// gated 16-bit timer/counter with ahb-lite register slave
// assumes single-word transfers, one ahb master, pins asynchronous to hclk
// Function
// - sixteen-bit count in two bytes, wraps from FFFF to 0000
// - every wrap sets the overflow flag, bit 0 of flags register
// - interrupt request needs overflow, peripheral and global enables set
// - internal source counts one per instruction cycle, via prescale and gate
// - external source counts rising edges of external clock pin
// - no external rising edge counts before a falling edge is seen
// - control bit 1 selects external pin (1) or internal clock (0)
// - control bit 2 lets counting go on in sleep in external mode; ignored otherwise
// - prescale bits 5:4 divide by 1, 2, 4 or 8
// - prescaler hidden from software, cleared on any count byte write
// - control bit 0 enables counting; cleared holds the count
// - gate enable bit 6 counts only while gate inactive, when on
// - gating applies to both internal and external clocking
// - gate source bit selects gate pin or comparator output
// - gate invert bit 7 inverts the selected gate signal
// - bit 3 enables low-power oscillator clock only under internal osc
// - all eight control bits read/write, reset to zero
// - asynchronous counter overflow can wake device from sleep
// - asynchronous mode keeps counting in sleep, overflow wakes processor
`timescale 1ns/1ns
`include "gtc_map.vh"

module gtc_timer (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire ext_clock_pin,
    input wire lp_osc_clock,
    input wire gate_pin,
    input wire comparator_output,
    output wire irq_request,
    output wire wake_request
);

// ----------------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------------
// two stages keep a metastable pin level away from the edge detectors;
// the price is three cycles from a pin edge to its count
reg [3:0] sync_a;
reg [3:0] sync_b;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sync_a <= 4'h0;
        sync_b <= 4'h0;
    end else if (clk_en) begin
        sync_a <= {comparator_output, gate_pin, lp_osc_clock, ext_clock_pin};
        sync_b <= sync_a;
    end
end
wire ext_s = sync_b[0];
wire lp_s = sync_b[1];
wire gpin_s = sync_b[2];
wire cmp_s = sync_b[3];

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg [7:0] timer_one_control;
reg [7:0] comparator_control_two;
reg [15:0] count;
reg overflow_flag;
reg [7:0] periph_enable_reg;
reg [7:0] irq_control_reg;
reg [1:0] system_state;
reg [2:0] prescale;
reg [1:0] instr_div;
reg ext_prev;
reg ext_armed;

wire [7:0] count_low_byte = count[7:0];
wire [7:0] count_high_byte = count[15:8];

// ahb address phase capture
reg wr_pend;
reg rd_pend;
reg [7:0] addr_q;
wire take = hsel & hready & htrans[1];
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
        addr_q <= 8'h00;
    end else if (clk_en) begin
        if (hready) begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            addr_q <= haddr[7:0];
        end
    end
end

function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
        hit = (a[7:2] == ofs[7:2]);
    end
endfunction

wire wr_ctrl = wr_pend & hit(addr_q, `GTC_OFS_CONTROL);
wire wr_low = wr_pend & hit(addr_q, `GTC_OFS_COUNT_LOW);
wire wr_high = wr_pend & hit(addr_q, `GTC_OFS_COUNT_HIGH);
wire wr_flags = wr_pend & hit(addr_q, `GTC_OFS_FLAGS);
wire wr_en = wr_pend & hit(addr_q, `GTC_OFS_ENABLES);
wire wr_gate = wr_pend & hit(addr_q, `GTC_OFS_GATE_CTRL);
wire wr_sys = wr_pend & hit(addr_q, `GTC_OFS_SYSTEM);

// ----------------------------------------------------------------------
// clock source, prescaler and gate
// ----------------------------------------------------------------------
wire ctl_on = timer_one_control[`GTC_BIT_ON];
wire ctl_cs = timer_one_control[`GTC_BIT_CS];
wire ctl_bypass = timer_one_control[`GTC_BIT_SYNC];
wire ctl_lp = timer_one_control[`GTC_BIT_LPOSC];
wire [1:0] prescale_select =
    timer_one_control[`GTC_BIT_PS_HI:`GTC_BIT_PS_LO];
wire gate_enable = timer_one_control[`GTC_BIT_GE];
wire gate_invert = timer_one_control[`GTC_BIT_GINV];
wire gate_source_select = comparator_control_two[`GTC_BIT_GSS];
wire sleeping = system_state[`GTC_BIT_SLEEP];
wire internal_oscillator = system_state[`GTC_BIT_INTERNAL_OSCILLATOR];

wire use_lp = ctl_lp & internal_oscillator;
wire ext_level = use_lp ? lp_s : ext_s;
wire ext_rise = ext_level & ~ext_prev;
wire ext_fall = ~ext_level & ext_prev;
// one tick every fourth hclk models the instruction cycle
wire int_tick = (instr_div == `GTC_INSTR_DIV);
// the external edge is already resampled by the pin synchroniser
// in both settings; bypass only decides whether counting goes on in sleep
wire async_mode = ctl_cs & ctl_bypass;
wire ext_tick = ext_rise & ext_armed;
wire src_tick = ctl_cs ? ext_tick : int_tick;

wire gate_sel = gate_source_select ? cmp_s : gpin_s;
wire gate_active = gate_invert ? gate_sel : ~gate_sel;
wire run = ctl_on & ~(gate_enable & gate_active) &
    (~sleeping | async_mode);
// in sleep only the asynchronous counter sees edges

function [2:0] ps_mask;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: ps_mask = 3'h0;
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end
endfunction

wire ps_done = ((prescale & ps_mask(prescale_select)) ==
    ps_mask(prescale_select));
wire step = run & src_tick & ps_done;
wire wrap = step & (count == `GTC_COUNT_MAX);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        instr_div <= 2'h0;
        ext_prev <= 1'b0;
        ext_armed <= 1'b0;
        prescale <= 3'h0;
    end else if (clk_en) begin
        instr_div <= instr_div + 2'h1;
        ext_prev <= ext_level;
        if (wr_ctrl)
            ext_armed <= 1'b0;
        else if (ext_fall)
            ext_armed <= 1'b1;
        if (wr_low | wr_high)
            prescale <= 3'h0;
        else if (run & src_tick)
            prescale <= ps_done ? 3'h0 : prescale + 3'h1;
    end
end

// ----------------------------------------------------------------------
// count
// ----------------------------------------------------------------------
// a byte write beats a count step in the same cycle, so software
// should stop the timer before writing or that step is lost
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        count <= `GTC_RST_COUNT;
    end else if (clk_en) begin
        // carry into high byte, wrap to zero
        if (wr_low) begin
            count <= {count_high_byte, hwdata[7:0]};
        end else if (wr_high) begin
            count <= {hwdata[7:0], count_low_byte};
        end else if (step) begin
            count <= count + 16'h0001;
        end
    end
end

// ----------------------------------------------------------------------
// overflow flag
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        overflow_flag <= 1'b0;
    end else if (clk_en) begin
        if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr_flags) begin
            overflow_flag <= hwdata[`GTC_BIT_OVF];
        end
    end
end

// ----------------------------------------------------------------------
// control and enable registers
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        timer_one_control <= `GTC_RST_CONTROL;
        comparator_control_two <= `GTC_RST_GATE_CTRL;
        periph_enable_reg <= 8'h00;
        irq_control_reg <= 8'h00;
    end else if (clk_en) begin
        if (wr_ctrl) begin
            timer_one_control <= hwdata[7:0];
        end
        // only the gate source bit and its neighbour are kept
        if (wr_gate) begin
            comparator_control_two <= {6'h00, hwdata[1:0]};
        end
        if (wr_en) begin
            periph_enable_reg <= hwdata[7:0];
        end
        if (wr_pend & hit(addr_q, `GTC_OFS_IRQ_CTRL)) begin
            irq_control_reg <= hwdata[7:0];
        end
    end
end

// ----------------------------------------------------------------------
// system state
// ----------------------------------------------------------------------
// a software write to the system register wins over a wake in the
// same cycle; software writing it knows what state it wants
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        system_state <= 2'h0;
    end else if (clk_en) begin
        if (wr_sys) begin
            system_state <= hwdata[1:0];
        end else if (wake_request) begin
            system_state[`GTC_BIT_SLEEP] <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// interrupt and wake requests
// ----------------------------------------------------------------------
// the irq request is a level held by the flag, so nothing is lost while the
// processor is slow to answer; wake drops once it has cleared sleep
// three-way enable
assign irq_request = overflow_flag &
    periph_enable_reg[`GTC_BIT_OVF_EN] &
    irq_control_reg[`GTC_BIT_PERIPH_IRQ_ENABLE] & irq_control_reg[`GTC_BIT_GIE];
assign wake_request = overflow_flag & sleeping &
    periph_enable_reg[`GTC_BIT_OVF_EN] & irq_control_reg[`GTC_BIT_PERIPH_IRQ_ENABLE];

// ----------------------------------------------------------------------
// read data
// ----------------------------------------------------------------------
// read data is captured in the address phase so it stands through the
// whole data phase; no register needs a wait state
reg [31:0] rdata;
reg [7:0] next_rdata;
always @* begin
    next_rdata = 8'h00;
    if (hit(haddr[7:0], `GTC_OFS_CONTROL))
        next_rdata = timer_one_control;
    else if (hit(haddr[7:0], `GTC_OFS_COUNT_LOW))
        next_rdata = count_low_byte;
    else if (hit(haddr[7:0], `GTC_OFS_COUNT_HIGH))
        next_rdata = count_high_byte;
    else if (hit(haddr[7:0], `GTC_OFS_FLAGS))
        next_rdata = {7'h00, overflow_flag};
    else if (hit(haddr[7:0], `GTC_OFS_ENABLES))
        next_rdata = periph_enable_reg;
    else if (hit(haddr[7:0], `GTC_OFS_GATE_CTRL))
        next_rdata = comparator_control_two;
    else if (hit(haddr[7:0], `GTC_OFS_SYSTEM))
        next_rdata = {6'h00, system_state};
    else if (hit(haddr[7:0], `GTC_OFS_IRQ_CTRL))
        next_rdata = irq_control_reg;
end
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        rdata <= 32'h00000000;
    else if (clk_en && take && !hwrite)
        rdata <= {24'h000000, next_rdata};
end
assign hrdata = rdata;
assign hreadyout = 1'b1;
assign hresp = 1'b0;

endmodule // gtc_timer
